// File: bset_pkg.sv
// Package with offsets, field layouts and reset values of the B-setting register bank
// Function
// - Bit 7 of the core-one B register selects synchronous (0) or sleep (1) for the first core converter under the B set.
// - Bits 6:0 of the core-one B register give 0.30 V at code 0 rising 0.01 V per code to 1.57 V.
// - Bit 7 of the processor B register selects synchronous (0) or sleep (1) for the processor converter under the B set.
// - Bits 6:0 of the processor B register give 0.53 V at code 0 rising 0.01 V per code to 1.80 V.
// - Bit 7 of the memory B register selects synchronous (0) or sleep (1) for the memory converter under the B set.
// - Memory, I/O and peripheral codes give 0.80 V at code 0 rising 0.02 V per code to 3.34 V.
// - Bit 7 of the I/O B register selects synchronous (0) or sleep (1) for the I/O converter under the B set.
// - Bit 7 of the peripheral B register selects synchronous (0) or sleep (1) for that converter under the B set.
// - Bit 7 of the third linear regulator B register selects normal (0) or sleep (1) under the B set.
// - Bits 6:0 of the third linear regulator B register give 0.90 V at code 0 rising 0.02 V per step to 3.44 V.
// - Core-one, processor and peripheral codes are targets within the PWM-mode output range.
package bset_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NREG = 8;
    localparam int IDX_W = 3;
    localparam logic [ADDR_W-1:0] BASE_OFFSET = 8'hB5;
    localparam logic [ADDR_W-1:0] CORE_ONE_OFFSET = 8'hB5;
    localparam logic [ADDR_W-1:0] PROCESSOR_OFFSET = 8'hB6;
    localparam logic [ADDR_W-1:0] MEMORY_OFFSET = 8'hB7;
    localparam logic [ADDR_W-1:0] IO_OFFSET = 8'hB8;
    localparam logic [ADDR_W-1:0] PERIPHERAL_OFFSET = 8'hB9;
    localparam logic [ADDR_W-1:0] RESERVED_A_OFFSET = 8'hBA;
    localparam logic [ADDR_W-1:0] RESERVED_B_OFFSET = 8'hBB;
    localparam logic [ADDR_W-1:0] LINEAR_THREE_OFFSET = 8'hBC;
    localparam int SLEEP_BIT = 7;
    localparam int CODE_MSB = 6;
    localparam int CODE_LSB = 0;
    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    // Voltage scale in millivolts: base and step per code
    localparam int CORE_ONE_BASE_MV = 300;
    localparam int CORE_ONE_STEP_MV = 10;
    localparam int PROCESSOR_BASE_MV = 530;
    localparam int PROCESSOR_STEP_MV = 10;
    localparam int WIDE_BUCK_BASE_MV = 800;
    localparam int WIDE_BUCK_STEP_MV = 20;
    localparam int LINEAR_THREE_BASE_MV = 900;
    localparam int LINEAR_THREE_STEP_MV = 20;
    localparam int MV_W = 12;

    typedef struct packed {
        logic sleep_sel;
        logic [CODE_MSB:CODE_LSB] volt_code;
    } setting_s;

    typedef struct packed {
        logic [MV_W-1:0] core_one_mv;
        logic [MV_W-1:0] processor_mv;
        logic [MV_W-1:0] memory_mv;
        logic [MV_W-1:0] io_mv;
        logic [MV_W-1:0] peripheral_mv;
        logic [MV_W-1:0] linear_three_mv;
    } targets_s;

    typedef struct packed {
        logic [NREG-1:0][DATA_W-1:0] bank;
        logic [DATA_W-1:0] rdata;
    } state_s;
endpackage

// File: regulator_b_setting_regs.sv
// B voltage setting register bank with per-regulator sleep selects and target voltages
`timescale 1ns/1ps
`default_nettype none
module regulator_b_setting_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [bset_pkg::ADDR_W-1:0] addr,
    input wire logic [bset_pkg::DATA_W-1:0] wdata,
    output logic [bset_pkg::DATA_W-1:0] rdata,
    output logic [5:0] sleep_sel_b,
    output bset_pkg::setting_s core_one_b,
    output bset_pkg::setting_s processor_b,
    output bset_pkg::setting_s memory_b,
    output bset_pkg::setting_s io_b,
    output bset_pkg::setting_s peripheral_b,
    output bset_pkg::setting_s linear_three_b,
    output bset_pkg::targets_s target_mv_b
);
    // Six regulators behind the bank, index 0 the first core converter
    localparam int NCONV = 6;

    // Registered bank and read data, and the next-state copy
    bset_pkg::state_s state_reg;
    bset_pkg::state_s state_next;

    // Decoded byte select, one bit per slot of the bank
    wire logic [bset_pkg::NREG-1:0] slot_sel;

    // Per-regulator view: register byte, sleep select and target
    wire bset_pkg::setting_s [NCONV-1:0] conv_setting;
    wire logic [NCONV-1:0] conv_sleep;
    wire logic [NCONV-1:0][bset_pkg::MV_W-1:0] conv_mv;

    // Address in range of the bank
    function automatic logic hit(input logic [bset_pkg::ADDR_W-1:0] a);
        hit = (a >= bset_pkg::CORE_ONE_OFFSET) && (a <= bset_pkg::LINEAR_THREE_OFFSET);
    endfunction

    // Bank index of an address
    function automatic logic [bset_pkg::IDX_W-1:0] idx(input logic [bset_pkg::ADDR_W-1:0] a);
        logic [bset_pkg::ADDR_W-1:0] d;
        d = a - bset_pkg::BASE_OFFSET;
        idx = d[bset_pkg::IDX_W-1:0];
    endfunction

    // Linear code to millivolts
    function automatic logic [bset_pkg::MV_W-1:0] to_mv(input logic [6:0] code,
            input int base, input int step);
        int v;
        v = base + step * int'(code);
        to_mv = v[bset_pkg::MV_W-1:0];
    endfunction

    // Bank slot that holds a regulator's setting byte
    function automatic logic [bset_pkg::IDX_W-1:0] conv_slot(input int k);
        case (k)
            0: conv_slot = idx(bset_pkg::CORE_ONE_OFFSET);
            1: conv_slot = idx(bset_pkg::PROCESSOR_OFFSET);
            2: conv_slot = idx(bset_pkg::MEMORY_OFFSET);
            3: conv_slot = idx(bset_pkg::IO_OFFSET);
            4: conv_slot = idx(bset_pkg::PERIPHERAL_OFFSET);
            5: conv_slot = idx(bset_pkg::LINEAR_THREE_OFFSET);
            default: conv_slot = idx(bset_pkg::CORE_ONE_OFFSET);
        endcase
    endfunction

    // Millivolts at code zero for each regulator
    function automatic int conv_base(input int k);
        case (k)
            0: conv_base = bset_pkg::CORE_ONE_BASE_MV;
            1: conv_base = bset_pkg::PROCESSOR_BASE_MV;
            2: conv_base = bset_pkg::WIDE_BUCK_BASE_MV;
            3: conv_base = bset_pkg::WIDE_BUCK_BASE_MV;
            4: conv_base = bset_pkg::WIDE_BUCK_BASE_MV;
            5: conv_base = bset_pkg::LINEAR_THREE_BASE_MV;
            default: conv_base = bset_pkg::CORE_ONE_BASE_MV;
        endcase
    endfunction

    // Millivolts per code step for each regulator
    function automatic int conv_step(input int k);
        case (k)
            0: conv_step = bset_pkg::CORE_ONE_STEP_MV;
            1: conv_step = bset_pkg::PROCESSOR_STEP_MV;
            2: conv_step = bset_pkg::WIDE_BUCK_STEP_MV;
            3: conv_step = bset_pkg::WIDE_BUCK_STEP_MV;
            4: conv_step = bset_pkg::WIDE_BUCK_STEP_MV;
            5: conv_step = bset_pkg::LINEAR_THREE_STEP_MV;
            default: conv_step = bset_pkg::CORE_ONE_STEP_MV;
        endcase
    endfunction

    // Byte select per slot; an address off the bank selects none
    for (genvar s = 0; s < bset_pkg::NREG; s++) begin : g_slot
        assign slot_sel[s] = hit(addr) && (idx(addr) == bset_pkg::IDX_W'(s));
    end

    // Whole-byte write into the selected slot, read data registered
    always_comb begin
        state_next = state_reg;
        for (int s = 0; s < bset_pkg::NREG; s++) begin
            if (wr_en && slot_sel[s]) begin
                state_next.bank[s] = wdata;
            end
        end
        // Reads see the old byte, so a same-cycle write shows up only later
        if (rd_en) begin
            state_next.rdata = bset_pkg::UNMAPPED_READ;
            for (int s = 0; s < bset_pkg::NREG; s++) begin
                if (slot_sel[s]) begin
                    state_next.rdata = state_reg.bank[s];
                end
            end
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{bank: {bset_pkg::NREG{bset_pkg::RESET_VALUE}},
                           rdata: bset_pkg::RESET_VALUE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;

    // Each regulator takes its byte, splits off the sleep select and scales its code
    for (genvar k = 0; k < NCONV; k++) begin : g_conv
        assign conv_setting[k] = state_reg.bank[conv_slot(k)];
        assign conv_sleep[k] = conv_setting[k].sleep_sel;
        assign conv_mv[k] = to_mv(conv_setting[k].volt_code, conv_base(k),
            conv_step(k));
    end

    // Register bytes to the regulators
    assign core_one_b = conv_setting[0];
    assign processor_b = conv_setting[1];
    assign memory_b = conv_setting[2];
    assign io_b = conv_setting[3];
    assign peripheral_b = conv_setting[4];
    assign linear_three_b = conv_setting[5];

    // Sleep selects: 1 sleep, 0 synchronous or normal
    assign sleep_sel_b = conv_sleep;

    // PWM-mode target voltages in millivolts, first core converter uppermost
    assign target_mv_b = '{
        core_one_mv: conv_mv[0],
        processor_mv: conv_mv[1],
        memory_mv: conv_mv[2],
        io_mv: conv_mv[3],
        peripheral_mv: conv_mv[4],
        linear_three_mv: conv_mv[5]
    };
endmodule
`default_nettype wire

// File: bset_asserts.sv
// Port assertions for the B-setting register bank
`timescale 1ns/1ps
`default_nettype none
module bset_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [5:0] sleep_sel_b,
    input wire bset_pkg::setting_s core_one_b,
    input wire bset_pkg::setting_s processor_b,
    input wire bset_pkg::setting_s linear_three_b,
    input wire bset_pkg::targets_s target_mv_b
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Sleep selects follow bit 7, targets follow the linear codes
    a_core_sleep: assert property (sleep_sel_b[0] == core_one_b[7]) else $error("core sleep");
    a_pro_sleep: assert property (sleep_sel_b[1] == processor_b[7]) else $error("pro sleep");
    a_lin_sleep: assert property (sleep_sel_b[5] == linear_three_b[7]) else $error("lin sleep");
    a_core_volt: assert property (target_mv_b.core_one_mv == 300 + 10 * core_one_b[6:0])
        else $error("core volt");
    a_pro_volt: assert property (target_mv_b.processor_mv == 530 + 10 * processor_b[6:0])
        else $error("pro volt");
    a_lin_volt: assert property (target_mv_b.linear_three_mv == 900 + 20 * linear_three_b[6:0])
        else $error("lin volt");
    // Writes land whole one cycle later, stray writes change nothing
    a_write_lands: assert property (wr_en && addr == 8'hB6 |=> processor_b == $past(wdata))
        else $error("write lost");
    a_stray_write: assert property (wr_en && addr > 8'hBC |=> $stable(core_one_b))
        else $error("stray write");
    // Memory, I/O and peripheral sleep selects and targets follow the last byte written to their own address
    a_mem_sleep: assert property (wr_en && addr == 8'hB7 |=>
        sleep_sel_b[2] == $past(wdata[7])) else $error("mem sleep");
    a_io_sleep: assert property (wr_en && addr == 8'hB8 |=>
        sleep_sel_b[3] == $past(wdata[7])) else $error("io sleep");
    a_peri_sleep: assert property (wr_en && addr == 8'hB9 |=>
        sleep_sel_b[4] == $past(wdata[7])) else $error("peri sleep");
    a_mem_volt: assert property (wr_en && addr == 8'hB7 |=>
        target_mv_b.memory_mv == 800 + 20 * $past(wdata[6:0])) else $error("mem volt");
    a_io_volt: assert property (wr_en && addr == 8'hB8 |=>
        target_mv_b.io_mv == 800 + 20 * $past(wdata[6:0])) else $error("io volt");
    a_peri_volt: assert property (wr_en && addr == 8'hB9 |=>
        target_mv_b.peripheral_mv == 800 + 20 * $past(wdata[6:0])) else $error("peri volt");
endmodule
bind regulator_b_setting_regs bset_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .sleep_sel_b(sleep_sel_b), .core_one_b(core_one_b),
    .processor_b(processor_b), .linear_three_b(linear_three_b), .target_mv_b(target_mv_b));
`default_nettype wire

// File: bset_host.sv
// Host bus model issuing one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module bset_host (
    input wire logic mclk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata
);
    initial {wr_en, rd_en, addr, wdata} = '0;
    // One access: strobe for one cycle, launched at the falling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
        @(negedge mclk);
        {wr_en, rd_en} = 2'b00;
    endtask
endmodule
`default_nettype wire

// File: regulator_b_setting_regs_tb_top.sv
// Self-checking bench for the B-setting register bank
`timescale 1ns/1ps
`default_nettype none
module regulator_b_setting_regs_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, rd_en;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] sleep_sel_b;
    bset_pkg::setting_s c1, pr, me, io, pe, l3;
    bset_pkg::targets_s tmv;
    int n_errors = 0;
    int checks = 0;
    // Rows: address, write data, expected read back
    logic [23:0] rows [9] = '{24'hB5FFFF, 24'hB68585, 24'hB77F7F, 24'hB88080, 24'hB90101,
        24'hBAA5A5, 24'hBB5A5A, 24'hBCFFFF, 24'hBD3300};
    always #10 mclk = ~mclk;
    bset_host i_host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
    regulator_b_setting_regs i_dut (.mclk(mclk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .rdata(rdata), .sleep_sel_b(sleep_sel_b), .core_one_b(c1),
        .processor_b(pr), .memory_b(me), .io_b(io), .peripheral_b(pe), .linear_three_b(l3),
        .target_mv_b(tmv));
    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset, row loop, then settled outputs and a mid-run reset
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        chk(tmv, {12'd300, 12'd530, 12'd800, 12'd800, 12'd800, 12'd900});
        foreach (rows[i]) begin
            i_host.acc(1'b1, rows[i][23:16], rows[i][15:8]);
            i_host.acc(1'b0, rows[i][23:16], 8'h00);
            chk(rdata, rows[i][7:0]);
        end
        chk(sleep_sel_b, 6'h2B);
        chk(tmv, {12'd1570, 12'd580, 12'd3340, 12'd800, 12'd820, 12'd3440});
        chk({c1, pr, me, io, pe, l3}, 48'hFF857F8001FF);
        rst_n = 1'b0;
        @(negedge mclk) rst_n = 1'b1;
        i_host.acc(1'b0, 8'hB5, 8'h00);
        chk(rdata, 8'h00);
        chk(tmv, {12'd300, 12'd530, 12'd800, 12'd800, 12'd800, 12'd900});
        final_report;
    end
endmodule
`default_nettype wire
